// file: design/breu_cond.sv
`timescale 1ns/1ns
// Condition field evaluation against the status flags
module breu_cond
  import breu_pkg::*;
(
  // Inputs
  input  wire logic [3:0] cond_in,
  input  wire logic [3:0] flags_in,
  // Result
  output logic            pass_out
);
  logic n, z, c, v;
  assign {n, z, c, v} = flags_in;

  // Standard sixteen-way condition decode
  always_comb
  begin
    case (cond_in)
      4'h0: pass_out = z;
      4'h1: pass_out = !z;
      4'h2: pass_out = c;
      4'h3: pass_out = !c;
      4'h4: pass_out = n;
      4'h5: pass_out = !n;
      4'h6: pass_out = v;
      4'h7: pass_out = !v;
      4'h8: pass_out = c && !z;
      4'h9: pass_out = !c || z;
      4'ha: pass_out = n == v;
      4'hb: pass_out = n != v;
      4'hc: pass_out = !z && (n == v);
      4'hd: pass_out = z || (n != v);
      4'he: pass_out = 1'b1;
      default: pass_out = 1'b0; // Never
    endcase
  end
endmodule

// file: design/breu_pkg.sv
package breu_pkg;
  // Mode field codes, unique per mode
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [4:0] MODE_SYS = 5'h1f;

  // Status word field positions
  localparam int SW_N_BIT   = 31;
  localparam int SW_Z_BIT   = 30;
  localparam int SW_C_BIT   = 29;
  localparam int SW_V_BIT   = 28;
  localparam int SW_IRQD_BIT = 7;
  localparam int SW_FIQD_BIT = 6;
  localparam int SW_T_BIT   = 5;

  // Reset value: supervisor, both interrupts disabled, full-width state
  localparam logic [31:0] SW_RESET = 32'h0000_00d3;

  // Exception vectors
  localparam logic [31:0] VEC_UND = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_ABT = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FAST = 32'h0000_001c;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  // Instruction widths per state
  localparam logic [31:0] STEP_FULL    = 32'h0000_0004;
  localparam logic [31:0] STEP_COMPACT = 32'h0000_0002;

  // Physical register count: 31 general plus 6 status
  localparam int NUM_GP   = 31;
  localparam int NUM_SW   = 6;
  localparam int NUM_PHYS = 37;

  // Bank index for saved status words and banked 13/14
  typedef enum logic [2:0] {
    BNK_USR, BNK_FAST, BNK_IRQ, BNK_SVC, BNK_ABT, BNK_UND
  } breu_bank_t;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_ABT, EXC_FAST, EXC_IRQ, EXC_UND, EXC_TRAP
  } breu_exc_t;

  // Exception source bundle
  typedef struct packed {
    logic abort;
    logic fast;
    logic irq;
    logic undef;
    logic swtrap;
  } breu_exc_src_t;

  // Write port bundle
  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } breu_wr_t;

  // Data access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
endpackage

// file: design/breu_top.sv
`timescale 1ns/1ns
// Functional notes
// - Instructions flow fetch, decode, execute in order.
// - Instructions are 32 bits in full state, 16 in compact state.
// - Byte, halfword, word data; halfword and word accesses aligned.
// - Seven operating modes supported.
// - Mode changes by software and automatically on exceptions.
// - 37 physical registers: 31 general, 6 status.
// - 16 visible registers, mapped by current mode.
// - Register 15 is the program counter, readable as operand.
// - Register 14 holds return address after call; 13 is stack.
// - Registers 0 to 7 share one physical copy in all modes.
// - Fast interrupt mode banks registers 8 to 12.
// - Each exception mode banks registers 13 and 14.
// - System mode uses user bank, privileged, exceptions allowed.
// - Status word holds flags, two disables, state bit, mode field.
// - Five saved status words capture status on exception entry.
// - Five exception types, each with its own mode.
// - Entry saves return address in banked 14 and status word.
// - Return copies saved status to current and RET_ADDR_IN to counter.
// - Simultaneous exceptions from several sources are handled.
// - Condition field bits 31 to 28 gates execution in full state.
// - Compact state shares registers 0 to 7; upper access limited (not here: indices 8 to 15 map as in full state).
module breu_top
  import breu_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          MCLK_IN,
  input  wire logic          RST_N_IN,
  input  wire logic          CE_IN,
  // Fetch side
  input  wire logic          FETCH_VALID_IN,
  input  wire logic [31:0]   FETCH_INSTR_IN,
  output logic [31:0]        FETCH_ADDR_OUT,
  // Execute operation from decode logic
  input  wire logic [3:0]    RD_A_IDX_IN,
  input  wire logic [3:0]    RD_B_IDX_IN,
  input  wire breu_wr_t      WR_IN,
  input  wire logic          WR_FLAGS_IN,
  input  wire logic [3:0]    FLAGS_IN,
  input  wire logic          BRANCH_LINK_IN,
  input  wire logic          BRANCH_IN,
  input  wire logic [31:0]   BRANCH_TGT_IN,
  input  wire logic          STATUS_WR_IN,
  input  wire logic [31:0]   STATUS_DATA_IN,
  input  wire logic          RET_DP_IN,
  input  wire logic          RET_MULTI_IN,
  input  wire logic [31:0]   RET_ADDR_IN,
  // Data access check
  input  wire logic [1:0]    ACC_SIZE_IN,
  input  wire logic [31:0]   ACC_ADDR_IN,
  output logic               ACC_MISALIGN_OUT,
  // Exception sources
  input  wire breu_exc_src_t EXC_IN,
  // Operands and state
  output logic [31:0]        RD_A_OUT,
  output logic [31:0]        RD_B_OUT,
  output logic [31:0]        DEC_INSTR_OUT,
  output logic               DEC_VALID_OUT,
  output logic               EXEC_PASS_OUT,
  output logic [31:0]        STATUS_OUT,
  output logic [31:0]        SAVED_STATUS_OUT,
  output logic               PRIV_OUT,
  output logic [2:0]         EXC_TAKEN_OUT
);
  logic        rst_s1_q, rst_s2_q;
  logic        rst_n;
  logic [31:0] pc_q;
  logic [31:0] cur_sw_q;
  logic [31:0] gp_q [NUM_GP];
  logic [31:0] saved_q [1:NUM_SW-1]; // Five saved status words
  logic [31:0] dec_instr_q;
  logic        dec_valid_q;
  logic [31:0] dec_pc_q;
  logic        pass;
  logic [4:0]  mode;
  breu_bank_t  bank;
  breu_exc_t   exc_sel;
  logic [4:0]  exc_mode;
  logic [31:0] exc_vec;
  breu_bank_t  exc_bank;
  logic [31:0] step;
  logic [31:0] ret_sw;
  logic        do_ret;
  logic        exec_ok;

  // All checks below run on the core clock and the internal reset
  default clocking cb_core @(posedge MCLK_IN);
  endclocking
  default disable iff (!rst_n);

  // Reset release through two flops
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Mode to bank; system deliberately shares the user bank
  function automatic breu_bank_t bank_of(input logic [4:0] m);
    case (m)
      MODE_FAST: bank_of = BNK_FAST;
      MODE_IRQ: bank_of = BNK_IRQ;
      MODE_SVC: bank_of = BNK_SVC;
      MODE_ABT: bank_of = BNK_ABT;
      MODE_UND: bank_of = BNK_UND;
      default:  bank_of = BNK_USR;
    endcase
  endfunction

  // Visible index to physical slot; slots 0-15 user, 16-20 fast 8-12,
  // 21-30 pairs of 13/14 for the five exception banks
  function automatic logic [4:0] phys_of(input logic [3:0] i,
                                         input breu_bank_t b);
    logic [4:0] r;
    r = {1'b0, i};
    if (i >= 4'h8 && i <= 4'hc && b == BNK_FAST)
      r = 5'(i) + 5'h08;
    else if (i >= 4'hd && i <= 4'he && b != BNK_USR)
      r = 5'h15 + 5'({b - 3'h1, 1'b0}) + 5'(i - 4'hd);
    phys_of = r;
  endfunction

  assign mode = cur_sw_q[4:0];
  assign bank = bank_of(mode);
  assign PRIV_OUT = mode != MODE_USR;
  assign step = cur_sw_q[SW_T_BIT] ? STEP_COMPACT : STEP_FULL;

  // Operand reads; index 15 gives the program counter
  always_comb
  begin
    RD_A_OUT = (RD_A_IDX_IN == 4'hf) ? dec_pc_q + (step << 1)
                                     : gp_q[phys_of(RD_A_IDX_IN, bank)];
    RD_B_OUT = (RD_B_IDX_IN == 4'hf) ? dec_pc_q + (step << 1)
                                     : gp_q[phys_of(RD_B_IDX_IN, bank)];
  end

  // Condition check on the decoded instruction; compact always runs
  breu_cond u_cond (
    .cond_in  (dec_instr_q[31:28]),
    .flags_in (cur_sw_q[31:28]),
    .pass_out (pass)
  );
  assign exec_ok = dec_valid_q && (cur_sw_q[SW_T_BIT] || pass);
  assign EXEC_PASS_OUT = exec_ok;

  // Fixed-priority exception arbitration, masked by disable bits
  always_comb
  begin
    exc_sel = EXC_NONE;
    if (EXC_IN.abort)
      exc_sel = EXC_ABT;
    else if (EXC_IN.fast && !cur_sw_q[SW_FIQD_BIT])
      exc_sel = EXC_FAST;
    else if (EXC_IN.irq && !cur_sw_q[SW_IRQD_BIT])
      exc_sel = EXC_IRQ;
    else if (EXC_IN.undef && dec_valid_q)
      exc_sel = EXC_UND;
    else if (EXC_IN.swtrap && exec_ok)
      exc_sel = EXC_TRAP;
  end

  // Target mode, vector and bank for the chosen exception
  always_comb
  begin
    case (exc_sel)
      EXC_ABT:  exc_mode = MODE_ABT;
      EXC_FAST: exc_mode = MODE_FAST;
      EXC_IRQ:  exc_mode = MODE_IRQ;
      EXC_UND:  exc_mode = MODE_UND;
      EXC_TRAP: exc_mode = MODE_SVC;
      default:  exc_mode = mode;
    endcase
    // Entry vector per exception class
    case (exc_sel)
      EXC_ABT:  exc_vec = VEC_ABT;
      EXC_FAST: exc_vec = VEC_FAST;
      EXC_IRQ:  exc_vec = VEC_IRQ;
      EXC_UND:  exc_vec = VEC_UND;
      EXC_TRAP: exc_vec = VEC_TRAP;
      default:  exc_vec = pc_q;
    endcase
    exc_bank = bank_of(exc_mode);
  end

  assign do_ret = exec_ok && (RET_DP_IN || RET_MULTI_IN);
  assign ret_sw = (bank == BNK_USR) ? cur_sw_q : saved_q[bank];

  // Fetch and decode stages; flushed on any redirect
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q        <= PC_RESET;
      dec_instr_q <= 32'h0000_0000;
      dec_valid_q <= 1'b0;
      dec_pc_q    <= PC_RESET;
    end
    else if (CE_IN)
    begin
      if (exc_sel != EXC_NONE)
      begin
        pc_q        <= exc_vec;
        dec_valid_q <= 1'b0;
      end
      else if (do_ret)
      begin
        pc_q        <= RET_ADDR_IN;
        dec_valid_q <= 1'b0;
      end
      else if (exec_ok && BRANCH_IN)
      begin
        pc_q        <= BRANCH_TGT_IN;
        dec_valid_q <= 1'b0;
      end
      else if (FETCH_VALID_IN)
      begin
        pc_q        <= pc_q + step;
        dec_instr_q <= FETCH_INSTR_IN;
        dec_pc_q    <= pc_q;
        dec_valid_q <= 1'b1;
      end
      else
        dec_valid_q <= 1'b0;
    end
  end

  // Current status word: entry, return, software write, flags
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      cur_sw_q <= SW_RESET;
    else if (CE_IN)
    begin
      if (exc_sel != EXC_NONE)
      begin
        cur_sw_q[4:0]        <= exc_mode;
        cur_sw_q[SW_T_BIT]   <= 1'b0;
        cur_sw_q[SW_IRQD_BIT] <= 1'b1;
        if (exc_sel == EXC_FAST || exc_sel == EXC_ABT)
          cur_sw_q[SW_FIQD_BIT] <= 1'b1;
      end
      else if (do_ret)
        cur_sw_q <= ret_sw;
      else if (exec_ok && STATUS_WR_IN && PRIV_OUT)
        cur_sw_q <= STATUS_DATA_IN;
      else if (exec_ok && WR_FLAGS_IN)
        cur_sw_q[31:28] <= FLAGS_IN;
    end
  end

  // Saved status words, one per exception bank
  generate
    for (genvar g = 1; g < NUM_SW; g++)
    begin : g_saved
      always_ff @(posedge MCLK_IN or negedge rst_n)
      begin
        if (!rst_n)
          saved_q[g] <= 32'h0000_0000;
        else if (CE_IN && exc_sel != EXC_NONE && exc_bank == 3'(g))
          saved_q[g] <= cur_sw_q;
      end
    end
  endgenerate

  // Physical general registers
  generate
    for (genvar r = 0; r < NUM_GP; r++)
    begin : g_gp
      always_ff @(posedge MCLK_IN or negedge rst_n)
      begin
        if (!rst_n)
          gp_q[r] <= 32'h0000_0000;
        else if (CE_IN)
        begin
          if (exc_sel != EXC_NONE)
          begin
            if (exc_bank != BNK_USR && 5'(r) == phys_of(4'he, exc_bank))
              gp_q[r] <= (exc_sel == EXC_UND || exc_sel == EXC_TRAP)
                         ? dec_pc_q + step : dec_pc_q;
          end
          else if (exec_ok && BRANCH_LINK_IN
                   && 5'(r) == phys_of(4'he, bank))
            gp_q[r] <= dec_pc_q + step;
          else if (exec_ok && WR_IN.en && WR_IN.idx != 4'hf
                   && 5'(r) == phys_of(WR_IN.idx, bank))
            gp_q[r] <= WR_IN.data;
        end
      end
    end
  endgenerate

  // Alignment check for halfword and word access
  always_comb
  begin
    case (ACC_SIZE_IN)
      SZ_HALF: ACC_MISALIGN_OUT = ACC_ADDR_IN[0];
      SZ_WORD: ACC_MISALIGN_OUT = |ACC_ADDR_IN[1:0];
      default: ACC_MISALIGN_OUT = 1'b0;
    endcase
  end

  assign FETCH_ADDR_OUT   = pc_q;
  assign DEC_INSTR_OUT    = dec_instr_q;
  assign DEC_VALID_OUT    = dec_valid_q;
  assign STATUS_OUT       = cur_sw_q;
  assign SAVED_STATUS_OUT = ret_sw;
  assign EXC_TAKEN_OUT    = exc_sel;

  // Checks
  a_abort_prio: assert property (
    (CE_IN && EXC_IN.abort) |=> cur_sw_q[4:0] == MODE_ABT)
    else $error("abort not taken first");
  a_saved_entry: assert property (
    (CE_IN && exc_sel == EXC_IRQ) |=> saved_q[2] == $past(cur_sw_q))
    else $error("saved status not captured");
  a_return_sw: assert property (
    (CE_IN && exc_sel == EXC_NONE && do_ret) |=> cur_sw_q == $past(ret_sw))
    else $error("status not restored");
  a_return_pc: assert property (
    (CE_IN && exc_sel == EXC_NONE && do_ret)
    |=> pc_q == $past(RET_ADDR_IN))
    else $error("counter not restored");
  a_fetch_step: assert property (
    (CE_IN && exc_sel == EXC_NONE && !do_ret && !(exec_ok && BRANCH_IN)
     && FETCH_VALID_IN) |=> pc_q == $past(pc_q) + $past(step))
    else $error("fetch step wrong");
  a_low_shared: assert property (
    RD_A_IDX_IN < 4'h8 |-> RD_A_OUT == gp_q[RD_A_IDX_IN])
    else $error("low register banked");
  a_cond_gate: assert property (
    (dec_valid_q && !cur_sw_q[SW_T_BIT] && !pass) |-> !EXEC_PASS_OUT)
    else $error("failed condition executed");
  a_fast_mask: assert property (
    (CE_IN && exc_sel == EXC_FAST) |=> cur_sw_q[SW_FIQD_BIT]
    && cur_sw_q[SW_IRQD_BIT] && cur_sw_q[4:0] == MODE_FAST)
    else $error("fast entry state wrong");
  a_align_word: assert property (
    (ACC_SIZE_IN == SZ_WORD && ACC_ADDR_IN[1:0] != 2'h0)
    |-> ACC_MISALIGN_OUT)
    else $error("misaligned word missed");
endmodule

// file: dv/banked_register_exception_unit_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module banked_register_exception_unit_test
  import breu_pkg::*;
();
  // Stimulus and observed outputs
  logic mclk, rst_n, ce, fvalid, wr_flags, br_link, br, st_wr;
  logic ret_dp, ret_multi, misalign, dec_valid, exec_pass, priv;
  logic [3:0] ra_idx, rb_idx, flags;
  logic [1:0] acc_size;
  logic [2:0] taken;
  logic [31:0] finstr, faddr, br_tgt, st_data, ret_addr, acc_addr;
  logic [31:0] rd_a, rd_b, dec_instr, status, saved;
  breu_wr_t wr;
  breu_exc_src_t exc;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  // Block under test
  breu_top dut (
    .MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce),
    .FETCH_VALID_IN(fvalid), .FETCH_INSTR_IN(finstr),
    .FETCH_ADDR_OUT(faddr), .RD_A_IDX_IN(ra_idx), .RD_B_IDX_IN(rb_idx),
    .WR_IN(wr), .WR_FLAGS_IN(wr_flags), .FLAGS_IN(flags),
    .BRANCH_LINK_IN(br_link), .BRANCH_IN(br), .BRANCH_TGT_IN(br_tgt),
    .STATUS_WR_IN(st_wr), .STATUS_DATA_IN(st_data), .RET_DP_IN(ret_dp),
    .RET_MULTI_IN(ret_multi), .RET_ADDR_IN(ret_addr),
    .ACC_SIZE_IN(acc_size), .ACC_ADDR_IN(acc_addr),
    .ACC_MISALIGN_OUT(misalign), .EXC_IN(exc), .RD_A_OUT(rd_a),
    .RD_B_OUT(rd_b), .DEC_INSTR_OUT(dec_instr),
    .DEC_VALID_OUT(dec_valid), .EXEC_PASS_OUT(exec_pass),
    .STATUS_OUT(status), .SAVED_STATUS_OUT(saved), .PRIV_OUT(priv),
    .EXC_TAKEN_OUT(taken)
  );
  // Far side: fetch stream and exception sources
  breu_src_model src (
    .fetch_valid_out(fvalid), .fetch_instr_out(finstr), .exc_out(exc)
  );

  // Inputs always move one step after the rising edge
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // Always lets one edge pass, so no strobe is set twice in a step
  task automatic wait_pass();
    tick();
    for (int i = 0; i < 8 && exec_pass !== 1'b1; i++)
      tick();
  endtask
  task automatic set_status(input logic [31:0] v);
    wait_pass();
    st_wr = 1'b1;
    st_data = v;
    tick();
    st_wr = 1'b0;
  endtask
  task automatic wr_reg(input logic [3:0] i, input logic [31:0] d);
    wait_pass();
    wr = '{en: 1'b1, idx: i, data: d};
    tick();
    wr.en = 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] i, output logic [31:0] d);
    ra_idx = i;
    #1;
    d = rd_a;
  endtask

  task automatic t_reset();
    `CHK("status", SW_RESET, status)
    `CHK("mode code", MODE_SVC, status[4:0])
    `CHK("pc", PC_RESET, faddr)
    `CHK("priv", 1'b1, priv)
    `CHK("taken", EXC_NONE, taken)
  endtask
  task automatic t_pipe();
    logic [31:0] a;
    src.set_fetch(1'b1, 32'he123_4567);
    a = faddr;
    tick();
    `CHK("dec valid", 1'b1, dec_valid)
    `CHK("dec instr", 32'he123_4567, dec_instr)
    `CHK("full step", a + STEP_FULL, faddr)
    ce = 1'b0;
    a = faddr;
    tick();
    `CHK("frozen pc", a, faddr)
    ce = 1'b1;
    rb_idx = 4'hf;
    #1;
    `CHK("pc operand", faddr + 32'h4, rd_b)
    set_status(32'h0000_00f3);
    a = faddr;
    tick();
    `CHK("compact step", a + STEP_COMPACT, faddr)
    set_status(SW_RESET);
  endtask
  task automatic t_cond();
    logic [15:0] exp_pass;
    exp_pass = 16'h66a9; // Outcome per code with only Z set
    wait_pass();
    wr_flags = 1'b1;
    flags = 4'h4;
    tick();
    wr_flags = 1'b0;
    `CHK("flags", 4'h4, status[31:28])
    src.set_fetch(1'b1, 32'h0000_0000);
    tick();
    `CHK("eq runs", 1'b1, exec_pass)
    src.set_fetch(1'b1, 32'h1000_0000);
    tick();
    `CHK("ne skipped", 1'b0, exec_pass)
    // Every condition code, one instruction per cycle
    for (int k = 0; k < 16; k++)
    begin
      src.set_fetch(1'b1, {4'(k), 28'h0});
      tick();
      `CHK("cond code", exp_pass[k], exec_pass)
    end
    src.set_fetch(1'b1, 32'he000_0000);
  endtask
  task automatic t_align();
    logic [1:0] sz [6];
    logic [1:0] lo [6];
    logic bad [6];
    sz = '{SZ_WORD, SZ_WORD, SZ_WORD, SZ_HALF, SZ_HALF, SZ_BYTE};
    lo = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3};
    bad = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      tick();
      acc_size = sz[i];
      acc_addr = 32'h0000_0100 + {30'h0, lo[i]};
      #1;
      `CHK("misalign", bad[i], misalign)
    end
  endtask
  task automatic t_bank();
    logic [31:0] v;
    wr_reg(4'h0, 32'h0000_0011);
    wr_reg(4'h8, 32'h0000_0022);
    wr_reg(4'hd, 32'h0000_0033);
    set_status(32'h0000_00d1);
    rd_reg(4'h0, v);
    `CHK("r0 shared", 32'h0000_0011, v)
    rd_reg(4'h8, v);
    `CHK("r8 fast", 32'h0, v)
    rd_reg(4'hd, v);
    `CHK("r13 fast", 32'h0, v)
    wr_reg(4'h8, 32'h0000_0044);
    set_status(32'h0000_00df);
    rd_reg(4'h8, v);
    `CHK("r8 system", 32'h0000_0022, v)
    rd_reg(4'hd, v);
    `CHK("r13 system", 32'h0, v)
    `CHK("system priv", 1'b1, priv)
    set_status(SW_RESET);
    rd_reg(4'hd, v);
    `CHK("r13 svc", 32'h0000_0033, v)
  endtask
  // Simultaneous sources: highest class wins, state saved in its bank
  task automatic t_exc();
    logic [4:0] sv [5];
    logic [2:0] tk [5];
    logic [4:0] md [5];
    logic [31:0] vec [5];
    logic [31:0] adj [5];
    logic [31:0] old, a, v;
    sv = '{5'b11111, 5'b01110, 5'b00101, 5'b00011, 5'b00001};
    tk = '{EXC_ABT, EXC_FAST, EXC_IRQ, EXC_UND, EXC_TRAP};
    md = '{MODE_ABT, MODE_FAST, MODE_IRQ, MODE_UND, MODE_SVC};
    vec = '{VEC_ABT, VEC_FAST, VEC_IRQ, VEC_UND, VEC_TRAP};
    adj = '{32'h4, 32'h4, 32'h4, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      set_status(32'h0000_001f);
      wait_pass();
      old = status;
      a = faddr;
      src.set_exc(breu_exc_src_t'(sv[i]));
      #1;
      `CHK("taken", tk[i], taken)
      tick();
      src.set_exc('0);
      `CHK("mode", md[i], status[4:0])
      `CHK("saved", old, saved)
      `CHK("vector", vec[i], faddr)
      rd_reg(4'he, v);
      `CHK("link", a - adj[i], v)
    end
    set_status(32'h0000_00df);
    wait_pass();
    src.set_exc(breu_exc_src_t'(5'b01100));
    #1;
    `CHK("masked", EXC_NONE, taken)
    tick();
    src.set_exc('0);
    `CHK("mode kept", MODE_SYS, status[4:0])
  endtask
  // Both return forms, each after a fresh entry
  task automatic t_ret();
    logic [31:0] v;
    for (int k = 0; k < 2; k++)
    begin
      set_status(32'h0000_001f);
      wait_pass();
      src.set_exc(breu_exc_src_t'(5'b00100));
      tick();
      src.set_exc('0);
      rd_reg(4'he, v);
      wait_pass();
      ret_dp = (k == 0);
      ret_multi = (k == 1);
      ret_addr = v;
      tick();
      ret_dp = 1'b0;
      ret_multi = 1'b0;
      `CHK("restored", 32'h0000_001f, status)
      `CHK("resume pc", v, faddr)
    end
  endtask
  task automatic t_link();
    logic [31:0] a, v;
    wait_pass();
    a = faddr;
    br = 1'b1;
    br_link = 1'b1;
    br_tgt = 32'h0000_0200;
    tick();
    br = 1'b0;
    br_link = 1'b0;
    `CHK("branch pc", 32'h0000_0200, faddr)
    rd_reg(4'he, v);
    `CHK("return addr", a, v)
  endtask
  // User mode cannot climb back by a status write
  task automatic t_user();
    logic [31:0] v;
    set_status(32'h0000_0010);
    `CHK("user priv", 1'b0, priv)
    set_status(SW_RESET);
    `CHK("user kept", MODE_USR, status[4:0])
    rd_reg(4'h8, v);
    `CHK("r8 user", 32'h0000_0022, v)
  endtask

  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Ceiling far above the hundred or so cycles the sequence needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      conclude();
    end
  end
  // Main sequence
  initial
  begin
    ce = 1'b1;
    {ra_idx, rb_idx, wr, wr_flags, flags, br_link, br, br_tgt} = '0;
    {st_wr, st_data, ret_dp, ret_multi, ret_addr, acc_size} = '0;
    acc_addr = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (3) tick();
    t_reset();
    t_pipe();
    t_cond();
    t_align();
    t_bank();
    t_exc();
    t_ret();
    t_link();
    t_user();
    conclude();
  end
endmodule

// file: dv/breu_src_model.sv
`timescale 1ns/1ns
// Decode-side stand-in: fetch stream and exception levels
module breu_src_model
  import breu_pkg::*;
(
  // Fetch stream
  output logic          fetch_valid_out,
  output logic [31:0]   fetch_instr_out,
  // Exception request levels
  output breu_exc_src_t exc_out
);
  // Quiet until the bench starts the stream after reset
  initial
  begin
    fetch_valid_out = 1'b0;
    fetch_instr_out = 32'he000_0000;
    exc_out = '0;
  end
  // Changed just after an edge, held until changed again
  task automatic set_fetch(input logic v, input logic [31:0] ins);
    fetch_valid_out = v;
    fetch_instr_out = ins;
  endtask
  // Levels, so several sources can rise in one cycle
  task automatic set_exc(input breu_exc_src_t e);
    exc_out = e;
  endtask
endmodule
